/* sysctl_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Call saves next address at stack pointer, loads target, sp += 2.
// - Jump loads any program address into the program counter.
// - Return-with-value loads its immediate into ACC, then returns.
// - Return does sp -= 2 and reloads pc from the stack there.
// - Interrupt return sets the global enable in the same cycle as it reloads pc.
// - Watchdog restart clears the watchdog count.
// - Computed jump sets pc to pc plus the accumulator.
// - Enable instruction sets the global interrupt enable.
// - Disable instruction clears the global interrupt enable.
// - Full halt stops all clocks including the oscillators.
// - CPU halt gates the CPU clock and keeps oscillators running.
// - Software reset resets the chip like a hardware reset.
// - No op here alters zero, carry, auxiliary carry or overflow flags.
// - Call, jump, computed jump, return and reti take two cycles.
module sysctl_unit
   import sysctl_pkg::*;
#(
   parameter int PCW = sysctl_pkg::PC_W
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         nrst_i,
   // Instruction issue
   input  wire logic                         valid_i,
   input  wire sysctl_pkg::instr_type        instr_i,
   input  wire logic                         wake_i,
   // Stack memory read data
   input  wire logic [sysctl_pkg::PC_W-1:0]  stack_rdata_i,
   // Core flags from the arithmetic path
   input  wire logic [3:0]                   flags_i,
   // Core state
   output logic [sysctl_pkg::PC_W-1:0]       pc_o,
   output logic [sysctl_pkg::SP_W-1:0]       sp_o,
   output logic [sysctl_pkg::DATA_W-1:0]     acc_o,
   output logic [3:0]                        flags_o,
   output logic                              gie_o,
   output logic                              busy_o,
   // Stack memory request
   output var sysctl_pkg::stack_req_type     stack_o,
   // System commands
   output logic                              wdt_clr_o,
   output logic                              osc_stop_o,
   output logic                              cpu_clk_gate_o,
   output logic                              chip_reset_o
);
   import sysctl_pkg::*;

   if (PCW != PC_W) begin : g_pcw_check
      $error("PCW must equal package PC_W");
   end

   state_type          state_q, state_d;
   logic [PC_W-1:0]    pc_q, pc_d;
   logic [SP_W-1:0]    sp_q, sp_d;
   logic [DATA_W-1:0]  acc_q, acc_d;
   logic [3:0]         flags_q, flags_d;
   logic               gie_q, gie_d;
   logic               osc_q, osc_d;
   logic               gate_q, gate_d;
   op_type             pend_q, pend_d;
   logic [PC_W-1:0]    tgt_q, tgt_d;
   stack_req_type      stk_q, stk_d;
   logic               busy_q, busy_d;
   logic               wd_fire;
   logic               rst_fire;
   logic               start;
   logic [PC_W-1:0]    acc_ext;

   assign start = valid_i && (state_q == ST_FETCH);
   assign acc_ext = {{(PC_W-DATA_W){1'b0}}, acc_q};

   // Next-state logic; two-cycle ops load pc in the second cycle
   always_comb begin
      state_d  = state_q;
      pc_d     = pc_q;
      sp_d     = sp_q;
      acc_d    = acc_q;
      flags_d  = flags_i;
      gie_d    = gie_q;
      osc_d    = osc_q;
      gate_d   = gate_q;
      pend_d   = pend_q;
      tgt_d    = tgt_q;
      stk_d    = '0;
      wd_fire  = 1'b0;
      rst_fire = 1'b0;
      case (state_q)
         ST_FETCH: begin
            if (valid_i) begin
               pend_d = instr_i.op;
               pc_d   = pc_q + PC_ONE;
               case (instr_i.op)
                  OP_CALL: begin
                     stk_d.we    = 1'b1;
                     stk_d.addr  = sp_q;
                     stk_d.wdata = pc_q + PC_ONE;
                     tgt_d       = instr_i.target;
                     state_d     = ST_SECOND;
                  end
                  OP_GOTO: begin
                     tgt_d   = instr_i.target;
                     state_d = ST_SECOND;
                  end
                  OP_RET_IMM, OP_RET, OP_RETI: begin
                     if (instr_i.op == OP_RET_IMM) begin
                        acc_d = instr_i.imm;
                     end
                     sp_d       = sp_q - SP_STEP;
                     stk_d.re   = 1'b1;
                     stk_d.addr = sp_q - SP_STEP;
                     state_d    = ST_SECOND;
                  end
                  OP_PCADD: begin
                     tgt_d   = pc_q + acc_ext;
                     state_d = ST_SECOND;
                  end
                  OP_WDRST:   wd_fire = 1'b1;
                  OP_ENGINT:  gie_d = 1'b1;
                  OP_DISGINT: gie_d = 1'b0;
                  OP_STOPSYS: begin
                     osc_d   = 1'b1;
                     gate_d  = 1'b1;
                     state_d = ST_HALT;
                  end
                  OP_STOPEXE: begin
                     gate_d  = 1'b1;
                     state_d = ST_HALT;
                  end
                  OP_SWRESET: rst_fire = 1'b1;
                  default: ;
               endcase
            end
         end
         ST_SECOND: begin
            state_d = ST_FETCH;
            case (pend_q)
               OP_CALL: begin
                  pc_d = tgt_q;
                  sp_d = sp_q + SP_STEP;
               end
               OP_GOTO, OP_PCADD: pc_d = tgt_q;
               OP_RET, OP_RET_IMM: pc_d = stack_rdata_i;
               OP_RETI: begin
                  pc_d  = stack_rdata_i;
                  gie_d = 1'b1;
               end
               default: ;
            endcase
         end
         ST_HALT: begin
            // Only a wake event or nrst_i restores clocks
            if (wake_i) begin
               osc_d   = 1'b0;
               gate_d  = 1'b0;
               state_d = ST_FETCH;
            end
         end
         default: state_d = ST_FETCH;
      endcase
      // Busy is registered from the next state so the pin is a flop output
      busy_d = (state_d != ST_FETCH);
   end

   // State registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_FETCH;
         pc_q    <= PC_RESET;
         sp_q    <= SP_RESET;
         acc_q   <= ACC_RESET;
         flags_q <= FLAGS_RESET;
         gie_q   <= 1'b0;
         osc_q   <= 1'b0;
         gate_q  <= 1'b0;
         pend_q  <= OP_NOP;
         tgt_q   <= PC_RESET;
         stk_q   <= '0;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         sp_q    <= sp_d;
         acc_q   <= acc_d;
         flags_q <= flags_d;
         gie_q   <= gie_d;
         osc_q   <= osc_d;
         gate_q  <= gate_d;
         pend_q  <= pend_d;
         tgt_q   <= tgt_d;
         stk_q   <= stk_d;
         busy_q  <= busy_d;
      end
   end

   // Strobes to the watchdog and the reset generator
   sysctl_pulse u_wd (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .fire_i  (wd_fire),
      .pulse_o (wdt_clr_o)
   );
   // Chip reset request; the reset block feeds it back onto nrst_i
   sysctl_pulse u_rst (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .fire_i  (rst_fire),
      .pulse_o (chip_reset_o)
   );

   // Outputs straight from flops
   assign pc_o           = pc_q;
   assign sp_o           = sp_q;
   assign acc_o          = acc_q;
   assign flags_o        = flags_q;
   assign gie_o          = gie_q;
   assign busy_o         = busy_q;
   assign stack_o        = stk_q;
   assign osc_stop_o     = osc_q;
   assign cpu_clk_gate_o = gate_q;

   // Assertions
   sequence s_call_issue;
      start && instr_i.op == OP_CALL;
   endsequence
   property p_call;
      @(posedge clk_i) disable iff (!nrst_i)
      s_call_issue |=> stk_q.we && stk_q.wdata == $past(pc_q) + PC_ONE
         && stk_q.addr == $past(sp_q)
         ##1 pc_q == $past(tgt_q) && sp_q == $past(sp_q) + SP_STEP;
   endproperty
   a_call: assert property (p_call) else $error("call wrong");

   property p_goto;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_GOTO |=> ##1 pc_q == $past(instr_i.target, 2);
   endproperty
   a_goto: assert property (p_goto) else $error("goto wrong");

   property p_retimm;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_RET_IMM |=> acc_q == $past(instr_i.imm);
   endproperty
   a_retimm: assert property (p_retimm) else $error("ret imm wrong");

   property p_ret;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_RET |=> sp_q == $past(sp_q) - SP_STEP
         && stk_q.re && stk_q.addr == sp_q;
   endproperty
   a_ret: assert property (p_ret) else $error("ret wrong");

   property p_reti;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_RETI |=> ##1 gie_q;
   endproperty
   a_reti: assert property (p_reti) else $error("reti no enable");

   property p_wd;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_WDRST |=> wdt_clr_o;
   endproperty
   a_wd: assert property (p_wd) else $error("no watchdog clear");

   property p_pcadd;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_PCADD |=> ##1
         pc_q == $past(pc_q, 2) + $past(acc_ext, 2);
   endproperty
   a_pcadd: assert property (p_pcadd) else $error("pcadd wrong");

   property p_gie;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op inside {OP_ENGINT, OP_DISGINT}
         |=> gie_q == ($past(instr_i.op) == OP_ENGINT);
   endproperty
   a_gie: assert property (p_gie) else $error("gie wrong");

   property p_halt;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_STOPEXE |=> cpu_clk_gate_o && !osc_stop_o;
   endproperty
   a_halt: assert property (p_halt) else $error("stopexe wrong");

   property p_sys;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_STOPSYS |=> osc_stop_o && cpu_clk_gate_o;
   endproperty
   a_sys: assert property (p_sys) else $error("stopsys wrong");

   property p_swrst;
      @(posedge clk_i) disable iff (!nrst_i)
      start && instr_i.op == OP_SWRESET |=> chip_reset_o ##1 !chip_reset_o;
   endproperty
   a_swrst: assert property (p_swrst) else $error("no reset pulse");

   // Two-cycle ops: busy in the second cycle, free again right after
   sequence s_dual_issue;
      start && instr_i.op inside {OP_CALL, OP_GOTO, OP_PCADD, OP_RET,
         OP_RET_IMM, OP_RETI};
   endsequence
   sequence s_dual_body;
      busy_o ##1 !busy_o;
   endsequence
   property p_dual;
      @(posedge clk_i) disable iff (!nrst_i)
      s_dual_issue |=> s_dual_body;
   endproperty
   a_dual: assert property (p_dual) else $error("not two cycles");

   property p_flags;
      @(posedge clk_i) disable iff (!nrst_i)
      1'b1 |=> flags_q == $past(flags_i);
   endproperty
   a_flags: assert property (p_flags) else $error("flags altered");
endmodule
`default_nettype wire

/* sysctl_pkg.sv */
`default_nettype none
package sysctl_pkg;

   // Widths
   localparam int PC_W = 12;
   localparam int SP_W = 8;
   localparam int DATA_W = 8;

   // Instruction codes of the system-control group
   typedef enum logic [3:0] {
      OP_NOP     = 4'h0,
      OP_CALL    = 4'h1,
      OP_GOTO    = 4'h2,
      OP_RET_IMM = 4'h3,
      OP_RET     = 4'h4,
      OP_RETI    = 4'h5,
      OP_WDRST   = 4'h6,
      OP_PCADD   = 4'h7,
      OP_ENGINT  = 4'h8,
      OP_DISGINT = 4'h9,
      OP_STOPSYS = 4'ha,
      OP_STOPEXE = 4'hb,
      OP_SWRESET = 4'hc
   } op_type;

   // Execution sequencer states, Gray coded
   typedef enum logic [1:0] {
      ST_FETCH  = 2'b00,
      ST_SECOND = 2'b01,
      ST_HALT   = 2'b10
   } state_type;

   // Decoded instruction carrier
   typedef struct packed {
      op_type              op;
      logic [PC_W-1:0]     target;
      logic [DATA_W-1:0]   imm;
   } instr_type;

   // Stack write / read request carrier
   typedef struct packed {
      logic                we;
      logic                re;
      logic [SP_W-1:0]     addr;
      logic [PC_W-1:0]     wdata;
   } stack_req_type;

   // Stack pointer step in bytes per saved address
   localparam logic [SP_W-1:0] SP_STEP = 8'h02;
   localparam logic [PC_W-1:0] PC_ONE = 12'h001;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [SP_W-1:0] SP_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage
`default_nettype wire

/* sysctl_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
// Registered one-cycle strobe output
module sysctl_pulse (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic fire_i,
   output logic      pulse_o
);
   logic pulse_q;
   logic pulse_d;

   // Next value is simply the request
   always_comb begin
      pulse_d = fire_i;
   end

   // Register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= pulse_d;
      end
   end

   assign pulse_o = pulse_q;
endmodule
`default_nettype wire

/* sysctl_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sysctl_unit_test;
   import sysctl_pkg::*;

   logic          clk_i;
   logic          nrst_i;
   logic          valid_i;
   instr_type     instr_i;
   logic          wake_i;
   logic [11:0]   stack_rdata_i;
   logic [3:0]    flags_i;
   logic [11:0]   pc_o;
   logic [7:0]    sp_o;
   logic [7:0]    acc_o;
   logic [3:0]    flags_o;
   logic          gie_o;
   logic          busy_o;
   stack_req_type stack_o;
   logic          wdt_clr_o;
   logic          osc_stop_o;
   logic          cpu_clk_gate_o;
   logic          chip_reset_o;
   int            n_errors = 0;
   int            checks = 0;
   int            cycles = 0;

   sysctl_unit uut (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i),
      .instr_i(instr_i), .wake_i(wake_i), .stack_rdata_i(stack_rdata_i),
      .flags_i(flags_i), .pc_o(pc_o), .sp_o(sp_o), .acc_o(acc_o),
      .flags_o(flags_o), .gie_o(gie_o), .busy_o(busy_o), .stack_o(stack_o),
      .wdt_clr_o(wdt_clr_o), .osc_stop_o(osc_stop_o),
      .cpu_clk_gate_o(cpu_clk_gate_o), .chip_reset_o(chip_reset_o));

   // 20 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Hang guard, well above the length of all tests together
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Issue one instruction; returns 1 ns after the edge that takes it.
   // Flags change with every issue so a stale copy shows up.
   task automatic issue(input op_type op, input logic [11:0] tgt,
                        input logic [7:0] imm);
      @(posedge clk_i);
      valid_i <= 1'b1;
      instr_i <= '{op: op, target: tgt, imm: imm};
      flags_i <= flags_i + 4'h5;
      @(posedge clk_i);
      valid_i <= 1'b0;
      #1;
      chk(flags_o, flags_i);
   endtask

   // Second cycle of a two-cycle op: busy must drop exactly here
   task automatic fin();
      chk(busy_o, 1'b1);
      @(posedge clk_i);
      #1;
      chk(busy_o, 1'b0);
   endtask

   task automatic t_call(input logic [11:0] tgt);
      logic [11:0] p;
      logic [7:0]  s;
      p = pc_o;
      s = sp_o;
      issue(OP_CALL, tgt, 8'h00);
      chk({stack_o.we, stack_o.addr}, {1'b1, s});
      chk(stack_o.wdata, 12'(p + 12'h001));
      fin();
      chk({pc_o, sp_o}, {tgt, s + 8'h02});
      $display("call test done");
   endtask

   // Return data is held over both cycles, then scrambled
   task automatic t_ret(input op_type op, input logic [11:0] v);
      logic [7:0] s;
      s = sp_o;
      @(posedge clk_i);
      stack_rdata_i <= v;
      issue(op, 12'h000, 8'h5a);
      chk({stack_o.re, stack_o.addr, sp_o}, {1'b1, s - 8'h02, s - 8'h02});
      if (op == OP_RETI)
         chk(gie_o, 1'b0);
      fin();
      chk(pc_o, v);
      if (op == OP_RETI)
         chk(gie_o, 1'b1);
      if (op == OP_RET_IMM)
         chk(acc_o, 8'h5a);
      @(posedge clk_i);
      stack_rdata_i <= ~v;
      $display("return test done");
   endtask

   task automatic t_jump();
      logic [11:0] p;
      issue(OP_GOTO, 12'hffe, 8'h00);
      fin();
      chk(pc_o, 12'hffe);
      p = pc_o;
      issue(OP_PCADD, 12'h000, 8'h00);
      fin();
      chk(pc_o, 12'(p + {4'h0, acc_o}));
      $display("jump test done");
   endtask

   task automatic t_one_cycle();
      logic [19:0] st;
      st = {sp_o, acc_o, gie_o, 3'h0};
      issue(OP_NOP, 12'h000, 8'h00);
      chk({sp_o, acc_o, gie_o, busy_o, 2'h0}, st);
      issue(OP_DISGINT, 12'h000, 8'h00);
      chk({gie_o, busy_o}, 2'b00);
      issue(OP_ENGINT, 12'h000, 8'h00);
      chk({gie_o, busy_o}, 2'b10);
      issue(OP_DISGINT, 12'h000, 8'h00);
      chk({gie_o, busy_o}, 2'b00);
      issue(OP_WDRST, 12'h000, 8'h00);
      chk(wdt_clr_o, 1'b1);
      @(posedge clk_i);
      #1;
      chk(wdt_clr_o, 1'b0);
      $display("single cycle test done");
   endtask

   task automatic t_halt(input op_type op, input logic [1:0] exp);
      logic [11:0] p;
      int          n;
      p = pc_o;
      issue(op, 12'h000, 8'h00);
      chk({osc_stop_o, cpu_clk_gate_o}, exp);
      chk(busy_o, 1'b1);
      issue(OP_GOTO, 12'h555, 8'h00);
      @(posedge clk_i);
      #1;
      chk(pc_o, 12'(p + 12'h001));
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      n = 0;
      while ((busy_o !== 1'b0) && n < 4) begin
         @(posedge clk_i);
         n++;
      end
      #1;
      chk({osc_stop_o, cpu_clk_gate_o, busy_o}, 3'b000);
      $display("halt test done");
   endtask

   // The pulse is meant to pull the chip reset, as the bench does here
   task automatic t_reset();
      issue(OP_SWRESET, 12'h000, 8'h00);
      chk(chip_reset_o, 1'b1);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      #1;
      chk(chip_reset_o, 1'b0);
      @(posedge clk_i);
      #1;
      chk({pc_o, sp_o, acc_o, gie_o, busy_o}, 30'h0);
      @(posedge clk_i);
      nrst_i <= 1'b1;
      $display("reset test done");
   endtask

   initial begin
      nrst_i = 1'b0;
      valid_i = 1'b0;
      instr_i = '0;
      wake_i = 1'b0;
      stack_rdata_i = 12'ha5a;
      flags_i = 4'h0;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_call(12'hfff);
      t_call(12'h123);
      t_ret(OP_RET_IMM, 12'h000);
      t_ret(OP_RET, 12'h001);
      t_call(12'h200);
      t_ret(OP_RETI, 12'h002);
      t_jump();
      t_one_cycle();
      t_halt(OP_STOPSYS, 2'b11);
      t_halt(OP_STOPEXE, 2'b01);
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
